// ### atx_pkg.sv
/*
  constants, field positions, modes and carrier types shared by the
  transmit control slice.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package atx_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned LINK_N  = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONFIG_TWO  = 4'h8;

  // tx_ctrl_status field positions
  localparam int unsigned BIT_TX_EN = 31;
  localparam int unsigned BIT_WSF   = 20;
  localparam int unsigned BIT_SEF   = 19;
  localparam int unsigned BIT_FEF   = 18;
  localparam int unsigned BIT_FWF   = 17;
  localparam int unsigned BIT_WORD_START_IRQ_EN  = 12;
  localparam int unsigned BIT_SYNC_ERR_IRQ_EN  = 11;
  localparam int unsigned BIT_FIFO_ERR_IRQ_EN  = 10;
  localparam int unsigned BIT_FIFO_WARN_IRQ_EN  = 9;
  localparam int unsigned BIT_FIFO_WARN_DMA_EN  = 1;

  // tx_config_two layout
  localparam int unsigned SYNC_HI = 31;
  localparam int unsigned SYNC_LO = 30;
  localparam logic [DATA_W-1:0] CONFIG_TWO_MASK  = 32'hff0000ff;
  localparam logic [DATA_W-1:0] CONFIG_TWO_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] CTRL_STATUS_MASK = 32'h801e1e02;

  // last bit count of a frame of 64 bit clocks, 8 bits wide like the bit counter
  localparam logic [7:0] FRAME_LAST = 8'h3f;

  typedef enum logic [1:0] {
    SYNC_ASYNC    = 2'b00,
    SYNC_RX       = 2'b01,
    SYNC_OTHER_TX = 2'b10,
    SYNC_OTHER_RX = 2'b11
  } atx_sync_t;

  typedef enum logic [2:0] {
    TX_OFF   = 3'b001,
    TX_ON    = 3'b010,
    TX_DRAIN = 3'b100
  } atx_state_t;

  typedef struct packed {
    logic word_start_irq_en;
    logic sync_err_irq_en;
    logic fifo_err_irq_en;
    logic fifo_warn_irq_en;
    logic fifo_warn_dma_en;
  } atx_en_t;

  typedef struct packed {
    logic word_start_flag;
    logic sync_error_flag;
    logic fef;
  } atx_flag_t;

endpackage

// ### atx_ctrl.sv
/*
  transmit control slice: enable sequencing, event flags, interrupt and
  dma request gating, synchronous mode selection, avalon-mm slave.
  assumes link pins are asynchronous to CLK_SYS and FIFO_EMPTY comes
  from logic on CLK_SYS.
*/
// The Avalon-MM register port was chosen for this implementation.
// Overview of operation
// - fifo warning bit 17 reads 1 while enabled transmit fifo is empty
// - bit 12 enables the word start interrupt
// - bit 11 enables the frame sync error interrupt
// - bit 10 enables the fifo underrun error interrupt
// - bit 9 enables the fifo warning interrupt
// - bit 1 lets the fifo warning dma request out
// - reserved bits of both registers are read only and read zero
// - mode bits 31:30 pick async, receiver sync or other transmitter sync
// - mode value 11 syncs the transmitter to another receiver
// - enable bit stays set until frame ends after software clears it, or drops at once if no frame has been seen since reset
`timescale 1ns/1ps
module atx_ctrl
  import atx_pkg::*;
(
  // clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST_N,
  // avalon-mm slave
  input  wire logic [atx_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [atx_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic      [atx_pkg::DATA_W-1:0] AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  // link sources: own pins, local rx, other tx, other rx
  input  wire logic [atx_pkg::LINK_N-1:0] LINK_BCLK,
  input  wire logic [atx_pkg::LINK_N-1:0] LINK_FS,
  // transmit fifo status
  input  wire logic                       FIFO_EMPTY,
  // requests and status
  output logic                            IRQ,
  output logic                            DMA_REQ,
  output logic                            TX_ACTIVE,
  output atx_pkg::atx_sync_t              SYNC_MODE
);
  import atx_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
                                              input logic [DATA_W-1:0] n,
                                              input logic [3:0] be);
    logic [DATA_W-1:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (n & m) | (o & ~m);
  endfunction

  logic                ack_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                wr_acc;
  logic                wr_ctrl;
  logic                wr_cfg;
  logic [DATA_W-1:0]   ctrl_rd;
  logic [DATA_W-1:0]   ctrl_new;
  logic [DATA_W-1:0]   cfg_q;
  atx_state_t          state_q;
  atx_state_t          state_d;
  atx_en_t             en_q;
  atx_flag_t           flag_q;
  atx_flag_t           flag_d;
  atx_flag_t           flag_clr;
  atx_flag_t           flag_evt;
  logic [LINK_N-1:0]   bclk_s1_q;
  logic [LINK_N-1:0]   bclk_s2_q;
  logic [LINK_N-1:0]   fs_s1_q;
  logic [LINK_N-1:0]   fs_s2_q;
  logic [1:0]          src;
  logic                bclk_sel;
  logic                fs_sel;
  logic                bclk_prev_q;
  logic                fs_last_q;
  logic                bclk_rise;
  logic                frame_start;
  logic                frame_end;
  logic                framed_q;
  logic [7:0]          cnt_q;
  logic                active;
  logic                fifo_warning_flag;

  // bus handshake: one wait cycle per access
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign wr_acc  = AVS_WRITE & ack_q;
  assign wr_ctrl = wr_acc & hit(AVS_ADDRESS, OFF_CTRL_STATUS);
  assign wr_cfg  = wr_acc & hit(AVS_ADDRESS, OFF_CONFIG_TWO);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
    end
  end

  // read data captured on the first edge, stands through the answer
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h00000000;
    end else if (AVS_READ && !ack_q) begin
      if (hit(AVS_ADDRESS, OFF_CTRL_STATUS)) begin
        rdata_q <= ctrl_rd & CTRL_STATUS_MASK;
      end else if (hit(AVS_ADDRESS, OFF_CONFIG_TWO)) begin
        rdata_q <= cfg_q & CONFIG_TWO_MASK;
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end
  assign AVS_READDATA = rdata_q;

  // status and control read image
  always_comb begin
    ctrl_rd            = 32'h00000000;
    ctrl_rd[BIT_TX_EN] = active;
    ctrl_rd[BIT_WSF]   = flag_q.word_start_flag;
    ctrl_rd[BIT_SEF]   = flag_q.sync_error_flag;
    ctrl_rd[BIT_FEF]   = flag_q.fef;
    ctrl_rd[BIT_FWF]   = fifo_warning_flag;
    ctrl_rd[BIT_WORD_START_IRQ_EN]  = en_q.word_start_irq_en;
    ctrl_rd[BIT_SYNC_ERR_IRQ_EN]  = en_q.sync_err_irq_en;
    ctrl_rd[BIT_FIFO_ERR_IRQ_EN]  = en_q.fifo_err_irq_en;
    ctrl_rd[BIT_FIFO_WARN_IRQ_EN]  = en_q.fifo_warn_irq_en;
    ctrl_rd[BIT_FIFO_WARN_DMA_EN]  = en_q.fifo_warn_dma_en;
  end
  assign ctrl_new = merge(ctrl_rd, AVS_WRITEDATA, AVS_BYTEENABLE);

  // interrupt and dma enables
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      en_q <= '0;
    end else if (wr_ctrl) begin
      en_q.word_start_irq_en <= ctrl_new[BIT_WORD_START_IRQ_EN];
      en_q.sync_err_irq_en <= ctrl_new[BIT_SYNC_ERR_IRQ_EN];
      en_q.fifo_err_irq_en <= ctrl_new[BIT_FIFO_ERR_IRQ_EN];
      en_q.fifo_warn_irq_en <= ctrl_new[BIT_FIFO_WARN_IRQ_EN];
      en_q.fifo_warn_dma_en <= ctrl_new[BIT_FIFO_WARN_DMA_EN];
    end
  end

  // config two: only defined fields are stored, software keeps it
  // steady while enabled
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= CONFIG_TWO_RESET;
    end else if (wr_cfg) begin
      cfg_q <= merge(cfg_q, AVS_WRITEDATA, AVS_BYTEENABLE) & CONFIG_TWO_MASK;
    end
  end
  assign SYNC_MODE = atx_sync_t'(cfg_q[SYNC_HI:SYNC_LO]);

  // two-stage synchronisers for every link source
  genvar gi;
  generate
    for (gi = 0; gi < LINK_N; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          bclk_s1_q[gi] <= 1'b0;
          bclk_s2_q[gi] <= 1'b0;
          fs_s1_q[gi]   <= 1'b0;
          fs_s2_q[gi]   <= 1'b0;
        end else begin
          bclk_s1_q[gi] <= LINK_BCLK[gi];
          bclk_s2_q[gi] <= bclk_s1_q[gi];
          fs_s1_q[gi]   <= LINK_FS[gi];
          fs_s2_q[gi]   <= fs_s1_q[gi];
        end
      end
    end
  endgenerate

  // clock source by mode: 00 own, 01 rx, 10 other tx, 11 other rx
  assign src      = cfg_q[SYNC_HI:SYNC_LO];
  assign bclk_sel = bclk_s2_q[src];
  assign fs_sel   = fs_s2_q[src];
  assign bclk_rise   = bclk_sel & ~bclk_prev_q;
  assign frame_start = bclk_rise & fs_sel & ~fs_last_q;
  assign frame_end   = bclk_rise & framed_q & ~frame_start &
                       (cnt_q == FRAME_LAST - 8'h01);

  // frame tracking on bit clock edges
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bclk_prev_q <= 1'b0;
      fs_last_q   <= 1'b0;
      cnt_q       <= 8'h00;
      framed_q    <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_sel;
      if (bclk_rise) begin
        fs_last_q <= fs_sel;
      end
      if (frame_start) begin
        cnt_q    <= 8'h00;
        framed_q <= 1'b1;
      end else if (bclk_rise && cnt_q != FRAME_LAST) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // enable sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      TX_OFF: begin
        if (wr_ctrl && AVS_BYTEENABLE[3] && ctrl_new[BIT_TX_EN]) begin
          state_d = TX_ON;
        end
      end
      TX_ON: begin
        if (wr_ctrl && AVS_BYTEENABLE[3] && !ctrl_new[BIT_TX_EN]) begin
          state_d = TX_DRAIN;
        end
      end
      TX_DRAIN: begin
        if (wr_ctrl && AVS_BYTEENABLE[3] && ctrl_new[BIT_TX_EN]) begin
          state_d = TX_ON;
        end else if (frame_end || !framed_q) begin
          state_d = TX_OFF;
        end
      end
      default: begin
        state_d = TX_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= TX_OFF;
    end else begin
      state_q <= state_d;
    end
  end
  assign active    = (state_q != TX_OFF);
  assign TX_ACTIVE = active;

  // events and sticky flags, a set wins over a write-one clear
  assign fifo_warning_flag          = active & FIFO_EMPTY;
  assign flag_evt.word_start_flag = active & frame_start;
  assign flag_evt.sync_error_flag = active & frame_start & framed_q &
                        (cnt_q != FRAME_LAST);
  assign flag_evt.fef = active & frame_start & FIFO_EMPTY;
  assign flag_clr.word_start_flag = wr_ctrl & AVS_BYTEENABLE[2] & AVS_WRITEDATA[BIT_WSF];
  assign flag_clr.sync_error_flag = wr_ctrl & AVS_BYTEENABLE[2] & AVS_WRITEDATA[BIT_SEF];
  assign flag_clr.fef = wr_ctrl & AVS_BYTEENABLE[2] & AVS_WRITEDATA[BIT_FEF];
  assign flag_d       = (flag_q & ~flag_clr) | flag_evt;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // interrupt and dma request gating
  assign IRQ = (flag_q.word_start_flag & en_q.word_start_irq_en) |
               (flag_q.sync_error_flag & en_q.sync_err_irq_en) |
               (flag_q.fef & en_q.fifo_err_irq_en) |
               (fifo_warning_flag & en_q.fifo_warn_irq_en);
  assign DMA_REQ = fifo_warning_flag & en_q.fifo_warn_dma_en;

  property p_fwf_read;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (AVS_READ && !ack_q && hit(AVS_ADDRESS, OFF_CTRL_STATUS))
      |=> (AVS_READDATA[BIT_FWF] == $past(active && FIFO_EMPTY));
  endproperty
  a_fwf_read: assert property (p_fwf_read)
    else $error("fifo warning bit read wrong");

  property p_word_start_irq_en_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_ctrl && AVS_BYTEENABLE[1] && AVS_WRITEDATA[BIT_WORD_START_IRQ_EN] && flag_d.word_start_flag)
      |=> IRQ;
  endproperty
  a_word_start_irq_en_gate: assert property (p_word_start_irq_en_gate)
    else $error("word start interrupt not raised");

  property p_sync_err_irq_en_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (flag_q.sync_error_flag && en_q.sync_err_irq_en) |-> IRQ;
  endproperty
  a_sync_err_irq_en_gate: assert property (p_sync_err_irq_en_gate)
    else $error("sync error interrupt missing");

  property p_fifo_err_irq_en_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (flag_evt.fef && en_q.fifo_err_irq_en && !wr_ctrl) |=> IRQ;
  endproperty
  a_fifo_err_irq_en_gate: assert property (p_fifo_err_irq_en_gate)
    else $error("fifo error interrupt missing");

  property p_fifo_warn_irq_en_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (active && FIFO_EMPTY && en_q.fifo_warn_irq_en) |-> IRQ;
  endproperty
  a_fifo_warn_irq_en_gate: assert property (p_fifo_warn_irq_en_gate)
    else $error("fifo warning interrupt missing");

  property p_dma_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(DMA_REQ) |-> (en_q.fifo_warn_dma_en && active && FIFO_EMPTY);
  endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("dma request without cause");

  property p_resv_zero;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, OFF_CONFIG_TWO))
      |-> ((AVS_READDATA & ~CONFIG_TWO_MASK) == 32'h00000000);
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved bits read nonzero");

  property p_sync_write;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_cfg && AVS_BYTEENABLE[3])
      |=> (SYNC_MODE == $past(AVS_WRITEDATA[SYNC_HI:SYNC_LO]));
  endproperty
  a_sync_write: assert property (p_sync_write)
    else $error("mode field not stored");

  property p_drain_hold;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (state_q == TX_ON && wr_ctrl && AVS_BYTEENABLE[3] &&
     !AVS_WRITEDATA[BIT_TX_EN] && framed_q && !frame_end)
      |=> (TX_ACTIVE && state_q == TX_DRAIN);
  endproperty
  a_drain_hold: assert property (p_drain_hold)
    else $error("transmitter stopped before frame end");

  property p_drain_end;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (state_q == TX_DRAIN && frame_end && !wr_ctrl) |=> !TX_ACTIVE;
  endproperty
  a_drain_end: assert property (p_drain_end)
    else $error("transmitter kept on after frame end");

  property p_irq_quiet;
    @(posedge CLK_SYS) disable iff (!RST_N)
    IRQ |-> ((flag_q.word_start_flag && en_q.word_start_irq_en) || (flag_q.sync_error_flag && en_q.sync_err_irq_en) ||
             (flag_q.fef && en_q.fifo_err_irq_en) || (fifo_warning_flag && en_q.fifo_warn_irq_en));
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt without enabled flag");

endmodule

// ### atx_link_model.sv
/*
  far side of the link: an audio device that makes bit clock and frame
  sync on one chosen source index.
  assumes the block samples the pins with its own clock.
*/
`timescale 1ns/1ps
module atx_link_model
  import atx_pkg::*;
(
  // link pins toward the block
  output logic [atx_pkg::LINK_N-1:0] BCLK,
  output logic [atx_pkg::LINK_N-1:0] FS
);
  initial begin
    BCLK = '0;
    FS   = '0;
  end

  // one frame of n bit clocks, 80 ns period; clock stands low after it
  task automatic frame(input int idx, input int n);
    #3;
    for (int i = 0; i < n; i++) begin
      FS[idx] = (i == 0);
      #40 BCLK[idx] = 1'b1;
      #40 BCLK[idx] = 1'b0;
    end
    FS[idx] = 1'b0;
  endtask
endmodule

// ### test_audio_tx_irq_dma_sync_ctrl.sv
/*
  testbench for the transmit control slice: register access, flags,
  interrupt and dma gating, mode select, enable drain.
  assumes atx_ctrl and atx_link_model from the same folder.
*/
`timescale 1ns/1ps
module test_audio_tx_irq_dma_sync_ctrl;
  import atx_pkg::*;
  logic              clk_sys    = 1'b0;
  logic              rst_n      = 1'b0;
  logic [ADDR_W-1:0] addr       = '0;
  logic              rd_en      = 1'b0;
  logic              wr_en      = 1'b0;
  logic [DATA_W-1:0] wdata      = '0;
  logic [3:0]        be         = 4'h0;
  logic              fifo_empty = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] got;
  logic              waitreq;
  logic              irq;
  logic              dma_req;
  logic              tx_active;
  atx_sync_t         sync_mode;
  logic [LINK_N-1:0] bclk;
  logic [LINK_N-1:0] fs;
  int                err_count  = 0;
  int                n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  atx_ctrl u_dut (
    .CLK_SYS         (clk_sys),
    .RST_N           (rst_n),
    .AVS_ADDRESS     (addr),
    .AVS_READ        (rd_en),
    .AVS_WRITE       (wr_en),
    .AVS_WRITEDATA   (wdata),
    .AVS_BYTEENABLE  (be),
    .AVS_READDATA    (rdata),
    .AVS_WAITREQUEST (waitreq),
    .LINK_BCLK       (bclk),
    .LINK_FS         (fs),
    .FIFO_EMPTY      (fifo_empty),
    .IRQ             (irq),
    .DMA_REQ         (dma_req),
    .TX_ACTIVE       (tx_active),
    .SYNC_MODE       (sync_mode)
  );

  atx_link_model u_link (
    .BCLK (bclk),
    .FS   (fs)
  );

  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // one avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk_sys);
    while (waitreq !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (waitreq !== 1'b0) begin
      err_count++;
      $display("ERROR %0t no bus answer", $time);
    end
    got = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [3:0] b);
    bus(1'b1, a, d, b);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b0, a, '0, 4'hf);
    chk(got, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task stop_test;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    err_count++;
    $display("ERROR %0t timeout", $time);
    stop_test;
  end

  initial begin
    cyc(16);
    rst_n <= 1'b1;
    rd(OFF_CTRL_STATUS, 32'h0);
    rd(OFF_CONFIG_TWO, CONFIG_TWO_RESET);
    rd(4'h4, 32'h0);
    wr(OFF_CONFIG_TWO, 32'hffffffff, 4'hf);
    rd(OFF_CONFIG_TWO, 32'hff0000ff);
    // every mode, written while the transmitter is off
    for (int m = 3; m >= 0; m--) begin
      wr(OFF_CONFIG_TWO, {m[1:0], 30'h0}, 4'hf);
      cyc(2);
      chk({30'h0, sync_mode}, m);
    end
    fifo_empty <= 1'b1;
    wr(OFF_CTRL_STATUS, 32'h7fffffff, 4'hf);
    rd(OFF_CTRL_STATUS, 32'h00001e02);
    chk({31'h0, dma_req}, 0);
    chk({31'h0, irq}, 0);
    wr(OFF_CTRL_STATUS, 32'h80000000, 4'hf);
    rd(OFF_CTRL_STATUS, 32'h80020000);
    chk({31'h0, dma_req}, 0);
    chk({31'h0, irq}, 0);
    wr(OFF_CTRL_STATUS, 32'h80000202, 4'hf);
    cyc(1);
    chk({31'h0, dma_req}, 1);
    chk({31'h0, irq}, 1);
    fifo_empty <= 1'b0;
    cyc(1);
    chk({31'h0, dma_req}, 0);
    chk({31'h0, irq}, 0);
    rd(OFF_CTRL_STATUS, 32'h80000202);
    // two whole frames with an empty fifo, then a short one and a whole one
    wr(OFF_CTRL_STATUS, 32'h80000000, 4'hf);
    fifo_empty <= 1'b1;
    u_link.frame(0, 64);
    u_link.frame(0, 64);
    cyc(8);
    rd(OFF_CTRL_STATUS, 32'h80160000);
    chk({31'h0, irq}, 0);
    u_link.frame(0, 10);
    u_link.frame(0, 64);
    cyc(8);
    fifo_empty <= 1'b0;
    cyc(1);
    rd(OFF_CTRL_STATUS, 32'h801c0000);
    // each interrupt enable alone against the set flags
    for (int k = 12; k >= 9; k--) begin
      wr(OFF_CTRL_STATUS, 32'h80000000 | (32'h1 << k), 4'hf);
      cyc(1);
      chk({31'h0, irq}, k != 9);
    end
    wr(OFF_CTRL_STATUS, 32'h001c0000, 4'h4);
    rd(OFF_CTRL_STATUS, 32'h80000200);
    chk({31'h0, irq}, 0);
    // stop requested in mid-frame
    fork
      u_link.frame(0, 64);
      begin
        cyc(40);
        wr(OFF_CTRL_STATUS, 32'h0, 4'hf);
        rd(OFF_CTRL_STATUS, 32'h80100000);
        chk({31'h0, tx_active}, 1);
      end
    join
    cyc(10);
    chk({31'h0, tx_active}, 0);
    rd(OFF_CTRL_STATUS, 32'h00100000);
    // mode 01 follows the receiver's link, not the own pins
    wr(OFF_CTRL_STATUS, 32'h00100000, 4'h4);
    wr(OFF_CONFIG_TWO, 32'h40000000, 4'hf);
    wr(OFF_CTRL_STATUS, 32'h80000000, 4'hf);
    u_link.frame(0, 64);
    cyc(8);
    rd(OFF_CTRL_STATUS, 32'h80000000);
    u_link.frame(1, 64);
    cyc(8);
    rd(OFF_CTRL_STATUS, 32'h80100000);
    stop_test;
  end
endmodule
